// ==== verilog/dtc_top.sv ====
// Dual cascadable 8-bit timer with Wishbone register access
// How it works
// - Lower channel: control plus period, width registers
// - Upper channel: control plus period, width registers
// - Upper control bit layout, resets to zero
// - Start bit clear stops and clears counter
// - Mode field selects seven documented modes and one reserved code
// - Clock select codes choose count source
// - Fields accepted in write that starts
// - Cascade clock lower, start/flop upper
// - Upper 16-bit byte counts lower overflow
`timescale 1ns/10ps
module dtc_top
    import dtc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Clock sources and pins
    input wire logic fs_tick_i,
    input wire logic lower_pin_i,
    input wire logic upper_pin_i,
    // Timer outputs
    output logic lower_ff_o,
    output logic upper_ff_o,
    output logic lower_match_o,
    output logic upper_match_o
);
    dtc_ctrl_type lower_ctrl_r;
    dtc_ctrl_type upper_ctrl_r;
    logic [7:0] lower_period_r;
    logic [7:0] lower_pwidth_r;
    logic [7:0] upper_period_r;
    logic [7:0] upper_pwidth_r;
    logic [1:0] cfg_r;
    logic [PRESC_W-1:0] presc_r;
    logic [PRESC_W-1:0] presc_nxt;
    logic [FS_DIV_LOG2-1:0] fs_cnt_r;
    logic [31:0] rd_nxt;
    logic ack_r;
    logic [31:0] dat_r;
    logic lff_r;
    logic uff_r;
    logic lmatch_r;
    logic umatch_r;

    wire req = wb_cyc_i && wb_stb_i && !ack_r;
    wire wr = req && wb_we_i && wb_sel_i[0];
    wire [7:0] wd = wb_dat_i[7:0];
    wire div_cfg = cfg_r[0];
    wire slow_mode = cfg_r[1];
    // Cascade selected by upper mode top bit
    wire cascade = upper_ctrl_r.mode[2];
    wire lower_run = cascade ? upper_ctrl_r.start : lower_ctrl_r.start;
    wire upper_run = upper_ctrl_r.start;
    wire lower_tick;
    wire upper_src_tick;
    wire [7:0] lower_cnt;
    wire [7:0] upper_cnt;
    wire lower_match;
    wire upper_match;
    wire lower_ff;
    wire upper_ff;
    wire upper_tick = cascade ? lower_match : upper_src_tick;
    wire [2:0] lower_mode = cascade ? M_TIMER8 : lower_ctrl_r.mode;
    wire [2:0] upper_mode = cascade ? (upper_ctrl_r.mode == M_PWM16 ? M_PWM8 : M_TIMER8)
        : upper_ctrl_r.mode;
    // Mode, clock and flop fields only take effect while stopped or starting
    wire lower_cfg_ok = !lower_ctrl_r.start;
    wire upper_cfg_ok = !upper_ctrl_r.start;
    wire upper_width_ok = !upper_run || upper_ctrl_r.mode == M_PWM8
        || upper_ctrl_r.mode == M_PWM16;
    wire lower_ff_load = wr && wb_adr_i == LOWER_CTRL_ADDR && lower_cfg_ok;
    wire upper_ff_load = wr && wb_adr_i == UPPER_CTRL_ADDR && upper_cfg_ok;

    assign presc_nxt = presc_r + {{(PRESC_W-1){1'b0}}, 1'b1};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            presc_r <= '0;
            fs_cnt_r <= '0;
        end else begin
            presc_r <= presc_nxt;
            if (fs_tick_i)
                fs_cnt_r <= fs_cnt_r + {{(FS_DIV_LOG2-1){1'b0}}, 1'b1};
        end
    end

    // Register writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lower_ctrl_r <= CTRL_RESET;
            upper_ctrl_r <= CTRL_RESET;
            lower_period_r <= 8'h00;
            lower_pwidth_r <= 8'h00;
            upper_period_r <= 8'h00;
            upper_pwidth_r <= 8'h00;
            cfg_r <= 2'h0;
        end else if (wr) begin
            unique case (wb_adr_i)
                LOWER_CTRL_ADDR: begin
                    lower_ctrl_r.start <= wd[START_BIT];
                    if (lower_cfg_ok) begin
                        lower_ctrl_r.ff <= wd[FF_BIT];
                        lower_ctrl_r.clk_sel <= wd[CK_MSB:CK_LSB];
                        lower_ctrl_r.mode <= wd[MODE_MSB:MODE_LSB];
                    end
                end
                UPPER_CTRL_ADDR: begin
                    upper_ctrl_r.start <= wd[START_BIT];
                    if (upper_cfg_ok) begin
                        upper_ctrl_r.ff <= wd[FF_BIT];
                        upper_ctrl_r.clk_sel <= wd[CK_MSB:CK_LSB];
                        upper_ctrl_r.mode <= wd[MODE_MSB:MODE_LSB];
                    end
                end
                LOWER_PERIOD_ADDR: lower_period_r <= wd;
                LOWER_PWIDTH_ADDR: lower_pwidth_r <= wd;
                UPPER_PERIOD_ADDR: begin
                    if (!upper_run)
                        upper_period_r <= wd;
                end
                UPPER_PWIDTH_ADDR: begin
                    if (upper_width_ok)
                        upper_pwidth_r <= wd;
                end
                CFG_ADDR: cfg_r <= wd[1:0];
                default: cfg_r <= cfg_r;
            endcase
        end
    end

    // Lower source select; cascade uses the lower selection too
    dtc_tick_sel u_lower_sel (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sel_i(lower_ctrl_r.clk_sel),
        .div_cfg_i(div_cfg),
        .slow_mode_i(slow_mode),
        .presc_i(presc_r),
        .presc_nxt_i(presc_nxt),
        .fs_tick_i(fs_tick_i),
        .fs_cnt_i(fs_cnt_r),
        .pin_i(lower_pin_i),
        .tick_o(lower_tick)
    );

    dtc_tick_sel u_upper_sel (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sel_i(upper_ctrl_r.clk_sel),
        .div_cfg_i(div_cfg),
        .slow_mode_i(slow_mode),
        .presc_i(presc_r),
        .presc_nxt_i(presc_nxt),
        .fs_tick_i(fs_tick_i),
        .fs_cnt_i(fs_cnt_r),
        .pin_i(upper_pin_i),
        .tick_o(upper_src_tick)
    );

    dtc_channel u_lower (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(lower_run),
        .tick_i(lower_tick),
        .mode_i(lower_mode),
        .ff_init_i(wd[FF_BIT]),
        .load_ff_i(lower_ff_load),
        .period_i(lower_period_r),
        .pwidth_i(lower_pwidth_r),
        .count_o(lower_cnt),
        .match_o(lower_match),
        .ff_o(lower_ff)
    );

    dtc_channel u_upper (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(upper_run),
        .tick_i(upper_tick),
        .mode_i(upper_mode),
        .ff_init_i(wd[FF_BIT]),
        .load_ff_i(upper_ff_load),
        .period_i(upper_period_r),
        .pwidth_i(upper_pwidth_r),
        .count_o(upper_cnt),
        .match_o(upper_match),
        .ff_o(upper_ff)
    );

    // Read mux
    always_comb begin
        rd_nxt = 32'h0000_0000;
        unique case (wb_adr_i)
            LOWER_CTRL_ADDR: rd_nxt[7:0] = lower_ctrl_r;
            UPPER_CTRL_ADDR: rd_nxt[7:0] = upper_ctrl_r;
            LOWER_PERIOD_ADDR: rd_nxt[7:0] = lower_period_r;
            LOWER_PWIDTH_ADDR: rd_nxt[7:0] = lower_pwidth_r;
            UPPER_PERIOD_ADDR: rd_nxt[7:0] = upper_period_r;
            UPPER_PWIDTH_ADDR: rd_nxt[7:0] = upper_pwidth_r;
            STATUS_ADDR: rd_nxt[17:0] = {upper_ff, lower_ff, upper_cnt, lower_cnt};
            CFG_ADDR: rd_nxt[1:0] = cfg_r;
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
            lff_r <= 1'b0;
            uff_r <= 1'b0;
            lmatch_r <= 1'b0;
            umatch_r <= 1'b0;
        end else begin
            ack_r <= req;
            dat_r <= req ? rd_nxt : 32'h0000_0000;
            lff_r <= lower_ff;
            uff_r <= upper_ff;
            lmatch_r <= lower_match;
            umatch_r <= upper_match;
        end
    end
    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign lower_ff_o = lff_r;
    assign upper_ff_o = uff_r;
    assign lower_match_o = lmatch_r;
    assign upper_match_o = umatch_r;

    // Two sampled edges in a row with the upper channel running
    sequence s_upper_steady;
        upper_run && $past(upper_run);
    endsequence

    // Registered ack: high for the cycle after the request, low the next
    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    a_stop_clears: assert property (@(posedge clk_i) disable iff (rst_i)
        !upper_run |=> upper_cnt == 8'h00)
        else $error("upper counter not cleared while stopped");
    a_cfg_locked: assert property (@(posedge clk_i) disable iff (rst_i)
        upper_ctrl_r.start && $past(upper_ctrl_r.start) |-> $stable(upper_ctrl_r.mode))
        else $error("upper mode changed while running");
    a_start_accepts: assert property (@(posedge clk_i) disable iff (rst_i)
        upper_ff_load |=> upper_ctrl_r.mode == $past(wd[MODE_MSB:MODE_LSB]))
        else $error("mode not taken at start");
    a_period_held: assert property (@(posedge clk_i) disable iff (rst_i)
        s_upper_steady |-> $stable(upper_period_r))
        else $error("upper period changed while running");
    a_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
        req |=> s_ack_pulse)
        else $error("ack not a single cycle");
    a_cascade_tick: assert property (@(posedge clk_i) disable iff (rst_i)
        cascade && upper_run && !lower_match |=> $stable(upper_cnt))
        else $error("upper byte moved without overflow");
    a_lower_follow: assert property (@(posedge clk_i) disable iff (rst_i)
        cascade && !upper_ctrl_r.start |=> lower_cnt == 8'h00)
        else $error("lower byte ran without upper start");
    a_reset_zero: assert property (@(posedge clk_i)
        rst_i |=> upper_ctrl_r == CTRL_RESET)
        else $error("upper control not zero after reset");
    a_lower_clears: assert property (@(posedge clk_i) disable iff (rst_i)
        !lower_run |=> lower_cnt == 8'h00)
        else $error("lower counter not cleared while stopped");
    a_upper_counts: assert property (@(posedge clk_i) disable iff (rst_i)
        upper_run && upper_tick && !upper_match && upper_mode != M_PWM8
        |=> upper_cnt == $past(upper_cnt) + 8'h01)
        else $error("upper counter did not advance on a tick");
    a_lower_locked: assert property (@(posedge clk_i) disable iff (rst_i)
        lower_ctrl_r.start && $past(lower_ctrl_r.start) |-> $stable(lower_ctrl_r.mode)
        && $stable(lower_ctrl_r.clk_sel) && $stable(lower_ctrl_r.ff))
        else $error("lower fields changed while running");
    // Upper width rewrites outside the PWM modes are dropped while running
    a_width_held: assert property (@(posedge clk_i) disable iff (rst_i)
        s_upper_steady ##0 (upper_ctrl_r.mode != M_PWM8 && upper_ctrl_r.mode != M_PWM16)
        |-> $stable(upper_pwidth_r))
        else $error("upper width changed while running");
    a_lower_ff_load: assert property (@(posedge clk_i) disable iff (rst_i)
        lower_ff_load && !lower_run |=> lower_ff == $past(wd[FF_BIT]))
        else $error("lower flop not loaded while stopped");
    a_upper_ff_load: assert property (@(posedge clk_i) disable iff (rst_i)
        upper_ff_load |=> upper_ff == $past(wd[FF_BIT]))
        else $error("upper flop not loaded while stopped");
    a_clock_taken: assert property (@(posedge clk_i) disable iff (rst_i)
        upper_ff_load |=> upper_ctrl_r.clk_sel == $past(wd[CK_MSB:CK_LSB]))
        else $error("clock select not taken while stopped");
    a_idle_no_ack: assert property (@(posedge clk_i) disable iff (rst_i)
        !req |=> !wb_ack_o && wb_dat_o == 32'h0000_0000)
        else $error("ack or data without a request");
endmodule

// ==== verilog/dtc_pkg.sv ====
// Register map, field layout and mode codes of the dual timer block
package dtc_pkg;
    localparam logic [7:0] LOWER_CTRL_ADDR = 8'h10;
    localparam logic [7:0] LOWER_PERIOD_ADDR = 8'h11;
    localparam logic [7:0] LOWER_PWIDTH_ADDR = 8'h12;
    localparam logic [7:0] UPPER_PERIOD_ADDR = 8'h13;
    localparam logic [7:0] UPPER_PWIDTH_ADDR = 8'h14;
    localparam logic [7:0] STATUS_ADDR = 8'h15;
    localparam logic [7:0] CFG_ADDR = 8'h16;
    localparam logic [7:0] UPPER_CTRL_ADDR = 8'h17;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int FF_BIT = 7;
    localparam int CK_MSB = 6;
    localparam int CK_LSB = 4;
    localparam int START_BIT = 3;
    localparam int MODE_MSB = 2;
    localparam int MODE_LSB = 0;
    localparam logic [2:0] M_TIMER8 = 3'h0;
    localparam logic [2:0] M_DIV8 = 3'h1;
    localparam logic [2:0] M_PWM8 = 3'h2;
    localparam logic [2:0] M_RSVD = 3'h3;
    localparam logic [2:0] M_TIMER16 = 3'h4;
    localparam logic [2:0] M_WARMUP = 3'h5;
    localparam logic [2:0] M_PWM16 = 3'h6;
    localparam logic [2:0] M_PULSE16 = 3'h7;
    localparam logic [2:0] CK_SLOWEST = 3'h0;
    localparam logic [2:0] CK_DIV128 = 3'h1;
    localparam logic [2:0] CK_DIV32 = 3'h2;
    localparam logic [2:0] CK_DIV8 = 3'h3;
    localparam logic [2:0] CK_FS = 3'h4;
    localparam logic [2:0] CK_DIV2 = 3'h5;
    localparam logic [2:0] CK_FC = 3'h6;
    localparam logic [2:0] CK_PIN = 3'h7;
    localparam int PRESC_W = 11;
    localparam int FS_DIV_LOG2 = 3;
    typedef struct packed {
        logic       ff;
        logic [2:0] clk_sel;
        logic       start;
        logic [2:0] mode;
    } dtc_ctrl_type;
endpackage

// ==== verilog/dtc_tick_sel.sv ====
// Count-source selector: prescaler taps, low clock ticks and pin edges
`timescale 1ns/10ps
module dtc_tick_sel
    import dtc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Source choice
    input wire logic [2:0] sel_i,
    input wire logic div_cfg_i,
    input wire logic slow_mode_i,
    input wire logic [PRESC_W-1:0] presc_i,
    input wire logic [PRESC_W-1:0] presc_nxt_i,
    input wire logic fs_tick_i,
    input wire logic [FS_DIV_LOG2-1:0] fs_cnt_i,
    input wire logic pin_i,
    // Selected tick
    output logic tick_o
);
    logic pin_s1_r;
    logic pin_s2_r;
    logic pin_s3_r;
    logic [PRESC_W-1:0] rise;
    logic tap;
    logic fs8_tick;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1_r <= 1'b0;
            pin_s2_r <= 1'b0;
            pin_s3_r <= 1'b0;
        end else begin
            pin_s1_r <= pin_i;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end

    // Bit k rising marks one fc/2^(k+1) period
    assign rise = presc_nxt_i & ~presc_i;
    assign fs8_tick = fs_tick_i && (fs_cnt_i == '1);

    always_comb begin
        tap = 1'b0;
        unique case (sel_i)
            CK_SLOWEST: tap = (div_cfg_i || slow_mode_i) ? fs8_tick : rise[10];
            CK_DIV128: tap = slow_mode_i ? 1'b0 : rise[6];
            CK_DIV32: tap = slow_mode_i ? 1'b0 : rise[4];
            CK_DIV8: tap = slow_mode_i ? 1'b0 : rise[2];
            CK_FS: tap = fs_tick_i;
            CK_DIV2: tap = slow_mode_i ? 1'b0 : rise[0];
            CK_FC: tap = 1'b1;
            CK_PIN: tap = pin_s2_r & ~pin_s3_r;
        endcase
    end
    assign tick_o = tap;
endmodule

// ==== verilog/dtc_channel.sv ====
// One 8-bit counter with compare, divider, PWM and pulse outputs
`timescale 1ns/10ps
module dtc_channel
    import dtc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic run_i,
    input wire logic tick_i,
    input wire logic [2:0] mode_i,
    input wire logic ff_init_i,
    input wire logic load_ff_i,
    input wire logic [7:0] period_i,
    input wire logic [7:0] pwidth_i,
    // Status
    output logic [7:0] count_o,
    output logic match_o,
    output logic ff_o
);
    logic [7:0] cnt_r;
    logic ff_r;
    logic hit_period;
    logic hit_width;
    logic pwm;

    assign pwm = (mode_i == M_PWM8);
    assign hit_period = run_i && tick_i && (cnt_r == period_i - 8'h01);
    assign hit_width = run_i && tick_i && (cnt_r == pwidth_i - 8'h01);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= 8'h00;
            ff_r <= 1'b0;
        end else if (!run_i) begin
            cnt_r <= 8'h00;
            if (load_ff_i)
                ff_r <= ff_init_i;
        end else if (tick_i) begin
            if (pwm) begin
                cnt_r <= cnt_r + 8'h01;
                if (hit_width || cnt_r == 8'hff)
                    ff_r <= ~ff_r;
            end else if (hit_period) begin
                cnt_r <= 8'h00;
                if (mode_i == M_DIV8)
                    ff_r <= ~ff_r;
            end else begin
                cnt_r <= cnt_r + 8'h01;
            end
        end
    end
    assign count_o = cnt_r;
    assign match_o = pwm ? (run_i && tick_i && cnt_r == 8'hff) : hit_period;
    assign ff_o = ff_r;
endmodule

// ==== dv/tb.sv ====
// Self-checking bench for the dual timer block
`timescale 1ns/10ps
module tb;
    import dtc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic fs_tick_i = 1'b0;
    logic lower_pin_i = 1'b0;
    logic upper_pin_i = 1'b0;
    logic lower_ff_o;
    logic upper_ff_o;
    logic lower_match_o;
    logic upper_match_o;
    logic [2:0] fs_div = 3'h0;
    logic [1:0] pin_div = 2'h0;
    logic pin_on = 1'b0;
    int cyc_cnt = 0;
    int fail_count = 0;
    int tests_run = 0;
    logic [63:0] exp_q[$];
    logic [63:0] ent;
    logic [2:0] cks[3] = '{CK_FC, CK_DIV2, CK_DIV32};
    int dv[3] = '{1, 2, 32};
    logic [7:0] p;
    logic [7:0] v;
    int hits;
    logic ff_seen;

    dtc_top dtc_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .fs_tick_i(fs_tick_i), .lower_pin_i(lower_pin_i), .upper_pin_i(upper_pin_i),
        .lower_ff_o(lower_ff_o), .upper_ff_o(upper_ff_o),
        .lower_match_o(lower_match_o), .upper_match_o(upper_match_o));

    always #50 clk_i = ~clk_i;

    // Low clock pulse every 8 cycles, each pin pulses every 4 cycles
    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        fs_div <= fs_div + 3'h1;
        fs_tick_i <= (fs_div == 3'h7);
        pin_div <= pin_div + 2'h1;
        lower_pin_i <= pin_on && (pin_div == 2'h0);
        upper_pin_i <= pin_on && (pin_div == 2'h2);
    end

    task automatic end_of_test();
        $display("Counts: %0d compared, %0d mismatched", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic hang(input string what);
        fail_count++;
        $display("BAD %0t no %s", $time, what);
        end_of_test();
    endtask

    // Reads carry a mask; writes queue a zero mask and are not compared
    always @(negedge clk_i) begin
        if (wb_ack_o === 1'b1) begin
            if (exp_q.size() == 0) begin
                hang("pending transfer for ack");
            end else begin
                ent = exp_q.pop_front();
                if (ent[63:32] != 32'h0) check(wb_dat_o & ent[63:32], ent[31:0]);
            end
        end
    end

    task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] dat,
                      input logic [31:0] msk, input logic [31:0] exp);
        int n;
        n = 0;
        exp_q.push_back({msk, exp});
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {24'h0, dat};
        do begin
            @(negedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) hang("bus ack");
        @(posedge clk_i);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
        wb(1'b1, adr, dat, 32'h0, 32'h0);
    endtask

    task automatic rd(input logic [7:0] adr, input logic [31:0] msk, input logic [31:0] exp);
        wb(1'b0, adr, 8'h00, msk, exp & msk);
    endtask

    function automatic logic [7:0] ctl(input logic f, input logic [2:0] c, input logic s,
                                       input logic [2:0] m);
        return {f, c, s, m};
    endfunction

    // Spacing between two consecutive match pulses, in clock cycles
    task automatic gap(input logic up, input int exp_n);
        int t0;
        int k;
        t0 = -1;
        for (k = 0; k < 3000; k++) begin
            @(negedge clk_i);
            if ((up ? upper_match_o : lower_match_o) === 1'b1) begin
                if (t0 >= 0) break;
                t0 = cyc_cnt;
            end
        end
        if (k >= 3000) hang("match pulse");
        check(32'(cyc_cnt - t0), 32'(exp_n));
    endtask

    initial begin
        void'($urandom(63983));
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 8'h10; a <= 8'h17; a++) rd(8'(a), 32'hffffffff, 32'h0);
        rd(8'h20, 32'hffffffff, 32'h0);
        wr(8'h20, 8'h5a);
        rd(8'h20, 32'hffffffff, 32'h0);
        $display("test reset values done");
        for (int a = 8'h11; a <= 8'h14; a++) begin
            v = 8'($urandom);
            wr(8'(a), v);
            rd(8'(a), 32'hff, {24'h0, v});
        end
        $display("test timer registers done");
        for (int m = 0; m < 8; m++) begin
            wr(UPPER_CTRL_ADDR, ctl(m[0], 3'(m), 1'b0, 3'(m)));
            rd(UPPER_CTRL_ADDR, 32'hff, {24'h0, ctl(m[0], 3'(m), 1'b0, 3'(m))});
        end
        wr(UPPER_CTRL_ADDR, CTRL_RESET);
        $display("test mode codes done");
        for (int i = 0; i < 3; i++) begin
            p = 8'(2 + $urandom % 6);
            wr(LOWER_PERIOD_ADDR, p);
            wr(LOWER_CTRL_ADDR, ctl(1'b0, cks[i], 1'b1, M_TIMER8));
            rd(LOWER_CTRL_ADDR, 32'hff, {24'h0, ctl(1'b0, cks[i], 1'b1, M_TIMER8)});
            gap(1'b0, int'(p) * dv[i]);
            wr(LOWER_CTRL_ADDR, ctl(1'b0, cks[i], 1'b0, M_TIMER8));
            rd(STATUS_ADDR, 32'hff, 32'h0);
        end
        $display("test clock sources done");
        wr(LOWER_CTRL_ADDR, ctl(1'b0, CK_FC, 1'b1, M_TIMER8));
        wr(LOWER_CTRL_ADDR, ctl(1'b1, CK_DIV2, 1'b1, M_DIV8));
        rd(LOWER_CTRL_ADDR, 32'hff, {24'h0, ctl(1'b0, CK_FC, 1'b1, M_TIMER8)});
        wr(LOWER_CTRL_ADDR, ctl(1'b0, CK_FC, 1'b0, M_TIMER8));
        wr(LOWER_CTRL_ADDR, ctl(1'b1, CK_FC, 1'b0, M_TIMER8));
        @(negedge clk_i);
        check({31'h0, lower_ff_o}, 32'h1);
        wr(LOWER_CTRL_ADDR, ctl(1'b0, CK_FC, 1'b0, M_TIMER8));
        @(negedge clk_i);
        check({31'h0, lower_ff_o}, 32'h0);
        wr(LOWER_PERIOD_ADDR, 8'h04);
        wr(LOWER_CTRL_ADDR, ctl(1'b0, CK_FC, 1'b1, M_DIV8));
        hits = 0;
        @(negedge clk_i);
        ff_seen = lower_ff_o;
        repeat (40) begin
            @(negedge clk_i);
            if (lower_ff_o !== ff_seen) hits++;
            ff_seen = lower_ff_o;
        end
        check(32'(hits), 32'h0a);
        wr(LOWER_CTRL_ADDR, ctl(1'b0, CK_FC, 1'b0, M_DIV8));
        wr(UPPER_CTRL_ADDR, ctl(1'b1, CK_FC, 1'b0, M_TIMER8));
        @(negedge clk_i);
        check({31'h0, upper_ff_o}, 32'h1);
        wr(UPPER_CTRL_ADDR, CTRL_RESET);
        @(negedge clk_i);
        check({31'h0, upper_ff_o}, 32'h0);
        $display("test running control done");
        wr(UPPER_PERIOD_ADDR, 8'h05);
        wr(UPPER_PWIDTH_ADDR, 8'h02);
        wr(UPPER_CTRL_ADDR, ctl(1'b0, CK_FC, 1'b1, M_TIMER8));
        gap(1'b1, 5);
        wr(UPPER_PERIOD_ADDR, 8'h09);
        rd(UPPER_PERIOD_ADDR, 32'hff, 32'h05);
        wr(UPPER_PWIDTH_ADDR, 8'h07);
        rd(UPPER_PWIDTH_ADDR, 32'hff, 32'h02);
        wr(UPPER_CTRL_ADDR, ctl(1'b0, CK_FC, 1'b0, M_TIMER8));
        wr(UPPER_CTRL_ADDR, ctl(1'b0, CK_FC, 1'b1, M_PWM8));
        wr(UPPER_PWIDTH_ADDR, 8'h07);
        rd(UPPER_PWIDTH_ADDR, 32'hff, 32'h07);
        wr(UPPER_CTRL_ADDR, ctl(1'b0, CK_FC, 1'b0, M_PWM8));
        $display("test upper registers done");
        // Upper clock field set to pin with the pin idle: only overflow may clock it
        wr(LOWER_CTRL_ADDR, ctl(1'b0, CK_FC, 1'b0, M_RSVD));
        wr(LOWER_PERIOD_ADDR, 8'h04);
        wr(UPPER_PERIOD_ADDR, 8'h03);
        wr(UPPER_CTRL_ADDR, ctl(1'b0, CK_PIN, 1'b1, M_TIMER16));
        gap(1'b1, 12);
        wr(UPPER_CTRL_ADDR, ctl(1'b0, CK_PIN, 1'b0, M_TIMER16));
        wr(UPPER_CTRL_ADDR, CTRL_RESET);
        $display("test cascade done");
        pin_on = 1'b1;
        wr(LOWER_PERIOD_ADDR, 8'h03);
        wr(LOWER_CTRL_ADDR, ctl(1'b0, CK_PIN, 1'b1, M_TIMER8));
        gap(1'b0, 12);
        wr(LOWER_CTRL_ADDR, ctl(1'b0, CK_PIN, 1'b0, M_TIMER8));
        wr(UPPER_PERIOD_ADDR, 8'h02);
        wr(UPPER_CTRL_ADDR, ctl(1'b0, CK_PIN, 1'b1, M_TIMER8));
        gap(1'b1, 8);
        wr(UPPER_CTRL_ADDR, ctl(1'b0, CK_PIN, 1'b0, M_TIMER8));
        pin_on = 1'b0;
        $display("test pin source done");
        wr(CFG_ADDR, 8'h02);
        wr(LOWER_PERIOD_ADDR, 8'h02);
        wr(LOWER_CTRL_ADDR, ctl(1'b0, CK_DIV2, 1'b1, M_TIMER8));
        hits = 0;
        repeat (200) begin
            @(negedge clk_i);
            if (lower_match_o === 1'b1) hits++;
        end
        check(32'(hits), 32'h0);
        wr(LOWER_CTRL_ADDR, ctl(1'b0, CK_DIV2, 1'b0, M_TIMER8));
        wr(CFG_ADDR, 8'h00);
        $display("test slow mode done");
        wr(UPPER_CTRL_ADDR, ctl(1'b1, CK_FC, 1'b1, M_PWM8));
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(UPPER_CTRL_ADDR, 32'hff, 32'h0);
        check({31'h0, upper_ff_o}, 32'h0);
        $display("test mid-run reset done");
        end_of_test();
    end
endmodule
